/* verilog/mcwr_pkg.sv */
// constants and types for the fieldbus communication supervision block
`default_nettype none
package mcwr_pkg;

  // special register word addresses
  localparam logic [15:0] ADDR_CMD       = 16'hfa00;
  localparam logic [15:0] ADDR_TIMEOUT   = 16'hfa01;
  localparam logic [15:0] ADDR_STATE     = 16'hfa02;
  localparam logic [15:0] ADDR_CONFIG    = 16'hfa03;
  localparam logic [15:0] ADDR_TCP_SUP   = 16'hfa04;
  localparam logic [15:0] ADDR_BLINK1    = 16'hfa0a;
  localparam logic [15:0] ADDR_BLINK2    = 16'hfa0b;
  localparam logic [15:0] ADDR_BLINK3    = 16'hfa0c;
  localparam logic [15:0] ADDR_RUN_STATE = 16'hfa0d;
  localparam logic [15:0] ADDR_CAT0      = 16'hfa10;
  localparam logic [15:0] ADDR_CAT1      = 16'hfa11;
  localparam logic [15:0] ADDR_CAT2      = 16'hfa12;
  localparam logic [15:0] ADDR_CAT3      = 16'hfa13;
  localparam logic [15:0] ADDR_FW_LEVEL  = 16'hfa14;
  localparam logic [15:0] ADDR_HW_LEVEL  = 16'hfa15;
  localparam logic [15:0] ADDR_BOOT_LVL  = 16'hfa16;
  localparam logic [15:0] ADDR_IMG_VER   = 16'hfa17;
  localparam logic [15:0] ADDR_NET0      = 16'hfa20;
  localparam logic [15:0] ADDR_NET1      = 16'hfa21;
  localparam logic [15:0] ADDR_NET2      = 16'hfa22;
  localparam logic [15:0] ADDR_IN_TOTAL  = 16'hfa40;
  localparam logic [15:0] ADDR_IN_ANA    = 16'hfa41;
  localparam logic [15:0] ADDR_IN_DIG    = 16'hfa42;
  localparam logic [15:0] ADDR_OUT_TOTAL = 16'hfa43;
  localparam logic [15:0] ADDR_OUT_ANA   = 16'hfa44;
  localparam logic [15:0] ADDR_OUT_DIG   = 16'hfa45;
  localparam logic [15:0] ADDR_PAT_A     = 16'hfaa0;
  localparam logic [15:0] ADDR_PAT_B     = 16'hfaa1;
  localparam logic [15:0] ADDR_PAT_C     = 16'hfaa2;
  localparam logic [15:0] ADDR_ALIVE     = 16'hfafa;

  // fixed contents
  localparam logic [15:0] SIZE_ANALOG    = 16'h7d00;
  localparam logic [15:0] SIZE_DIGITAL   = 16'h8000;
  localparam logic [15:0] PATTERN_A      = 16'h1234;
  localparam logic [15:0] PATTERN_B      = 16'haaaa;
  localparam logic [15:0] PATTERN_C      = 16'h5555;
  localparam logic [15:0] RUN_CODE_STOP  = 16'h0001;
  localparam logic [15:0] RUN_CODE_RUN   = 16'h0002;

  // command words
  localparam logic [15:0] CMD_START      = 16'h5555;
  localparam logic [15:0] CMD_STOP       = 16'h55aa;
  localparam logic [15:0] CMD_RESET      = 16'haaaa;

  // status encodings
  localparam logic [15:0] STAT_NO_TMO    = 16'hffff;
  localparam logic [15:0] STAT_STOPPED   = 16'h0000;
  localparam logic [15:0] STAT_RUNNING   = 16'h0001;
  localparam logic [15:0] STAT_EXPIRED   = 16'h0002;

  // exception codes
  localparam logic [7:0]  EXC_NONE       = 8'h00;
  localparam logic [7:0]  EXC_BAD_FUNC   = 8'h01;
  localparam logic [7:0]  EXC_BAD_ADDR   = 8'h02;
  localparam logic [7:0]  EXC_BAD_VALUE  = 8'h03;

  // configuration field positions and reset values
  localparam int          CFG_CLOSE_TCP_BIT  = 0;
  localparam int          CFG_STATE_TRIG_BIT = 1;
  localparam int          CFG_EXPLICIT_BIT   = 2;
  localparam int          CFG_MODE_BIT       = 7;
  localparam logic [15:0] CONFIG_RESET   = 16'h0000;
  localparam logic [15:0] TIMEOUT_RESET  = 16'h0000;
  localparam logic [15:0] TCP_SUP_RESET  = 16'h0000;

  // timing: one timeout step, and the clock period
  localparam int          STEP_NS        = 1000000;
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          STEP_CYCLES    = STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MCWR_NO_TMO,
    MCWR_STOPPED,
    MCWR_RUNNING,
    MCWR_EXPIRED
  } mcwr_state_t;

endpackage
`default_nettype wire

/* verilog/mcwr_top.sv */
// fieldbus communication supervision timer with its special register window
`timescale 1ns/1ps
`default_nettype none

module mcwr_top
  import mcwr_pkg::*;
#(
  parameter int          STEP_CYCLES_P = STEP_CYCLES,
  // arbitrary neutral identity values
  parameter logic [63:0] CATALOGUE_NUM = 64'h0000000000000001,
  parameter logic [15:0] IMAGE_VERSION = 16'h0001
) (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  // register request from the protocol engine
  input  wire logic        I_REQ_VALID,
  input  wire logic        I_REQ_WRITE,
  input  wire logic [15:0] I_REQ_ADDR,
  input  wire logic [15:0] I_REQ_WDATA,
  // device information shown in the window
  input  wire logic [15:0] I_BLINK_PART1,
  input  wire logic [15:0] I_BLINK_PART2,
  input  wire logic [15:0] I_BLINK_PART3,
  input  wire logic        I_CTRL_RUNNING,
  input  wire logic [15:0] I_FW_LEVEL,
  input  wire logic [15:0] I_HW_LEVEL,
  input  wire logic [15:0] I_BOOT_LEVEL,
  input  wire logic [47:0] I_NET_HW_ADDR,
  // register answer
  output logic             O_RSP_VALID,
  output logic [15:0]      O_RSP_RDATA,
  output logic [7:0]       O_RSP_EXC,
  // supervision outputs
  output logic             O_TIMEOUT,
  output logic             O_CLOSE_TCP,
  output logic [15:0]      O_TCP_SUPERVISION
);

  localparam int PW = $clog2(STEP_CYCLES_P + 1);

  mcwr_state_t   st_q;
  mcwr_state_t   st_d;
  logic [15:0]   tmo_q;
  logic [15:0]   tmo_d;
  logic [15:0]   cfg_q;
  logic [15:0]   cfg_d;
  logic [15:0]   tcp_q;
  logic [15:0]   tcp_d;
  logic [PW-1:0] pre_q;
  logic [15:0]   ms_cnt_q;
  logic [15:0]   alive_q;
  logic [15:0]   rdata;
  logic [7:0]    exc;
  logic          hit;
  logic          trig;
  logic          restart;
  logic          expire;
  logic          tick;
  logic          is_auto;

  // status word for each state
  function automatic logic [15:0] state_code(input mcwr_state_t s);
    logic [15:0] c;
    c = STAT_NO_TMO;
    unique case (s)
      MCWR_NO_TMO:  c = STAT_NO_TMO;
      MCWR_STOPPED: c = STAT_STOPPED;
      MCWR_RUNNING: c = STAT_RUNNING;
      MCWR_EXPIRED: c = STAT_EXPIRED;
    endcase
    return c;
  endfunction

  // readable word lookup; bit 16 marks a mapped address
  function automatic logic [16:0] lookup(input logic [15:0] a);
    logic [16:0] r;
    r = {1'b1, 16'h0000};
    unique case (a)
      ADDR_CMD:       r = {1'b1, 16'h0000};
      ADDR_TIMEOUT:   r = {1'b1, tmo_q};
      ADDR_STATE:     r = {1'b1, state_code(st_q)};
      ADDR_CONFIG:    r = {1'b1, cfg_q};
      ADDR_TCP_SUP:   r = {1'b1, tcp_q};
      ADDR_BLINK1:    r = {1'b1, I_BLINK_PART1};
      ADDR_BLINK2:    r = {1'b1, I_BLINK_PART2};
      ADDR_BLINK3:    r = {1'b1, I_BLINK_PART3};
      ADDR_RUN_STATE: r = {1'b1, I_CTRL_RUNNING ? RUN_CODE_RUN : RUN_CODE_STOP};
      ADDR_CAT0:      r = {1'b1, CATALOGUE_NUM[63:48]};
      ADDR_CAT1:      r = {1'b1, CATALOGUE_NUM[47:32]};
      ADDR_CAT2:      r = {1'b1, CATALOGUE_NUM[31:16]};
      ADDR_CAT3:      r = {1'b1, CATALOGUE_NUM[15:0]};
      ADDR_FW_LEVEL:  r = {1'b1, I_FW_LEVEL};
      ADDR_HW_LEVEL:  r = {1'b1, I_HW_LEVEL};
      ADDR_BOOT_LVL:  r = {1'b1, I_BOOT_LEVEL};
      ADDR_IMG_VER:   r = {1'b1, IMAGE_VERSION};
      ADDR_NET0:      r = {1'b1, I_NET_HW_ADDR[47:32]};
      ADDR_NET1:      r = {1'b1, I_NET_HW_ADDR[31:16]};
      ADDR_NET2:      r = {1'b1, I_NET_HW_ADDR[15:0]};
      ADDR_IN_TOTAL:  r = {1'b1, SIZE_ANALOG};
      ADDR_IN_ANA:    r = {1'b1, SIZE_ANALOG};
      ADDR_IN_DIG:    r = {1'b1, SIZE_DIGITAL};
      ADDR_OUT_TOTAL: r = {1'b1, SIZE_ANALOG};
      ADDR_OUT_ANA:   r = {1'b1, SIZE_ANALOG};
      ADDR_OUT_DIG:   r = {1'b1, SIZE_DIGITAL};
      ADDR_PAT_A:     r = {1'b1, PATTERN_A};
      ADDR_PAT_B:     r = {1'b1, PATTERN_B};
      ADDR_PAT_C:     r = {1'b1, PATTERN_C};
      ADDR_ALIVE:     r = {1'b1, alive_q};
      default:        r = {1'b0, 16'h0000};
    endcase
    return r;
  endfunction

  assign is_auto = cfg_q[CFG_MODE_BIT];
  assign tick    = (pre_q == PW'(STEP_CYCLES_P - 1));

  // request decode, command handling and state transitions
  always_comb begin
    st_d    = st_q;
    tmo_d   = tmo_q;
    cfg_d   = cfg_q;
    tcp_d   = tcp_q;
    exc     = EXC_NONE;
    {hit, rdata} = lookup(I_REQ_ADDR);
    trig    = 1'b0;
    restart = 1'b0;
    expire  = 1'b0;
    if (I_REQ_VALID) begin
      if (!hit) begin
        exc   = EXC_BAD_ADDR;
        rdata = 16'h0000;
      end else if (!I_REQ_WRITE) begin
        if (I_REQ_ADDR == ADDR_CMD) begin
          exc   = EXC_BAD_FUNC;
          rdata = 16'h0000;
        end
      end else begin
        rdata = 16'h0000;
        unique case (I_REQ_ADDR)
          ADDR_CMD: begin
            if (I_REQ_WDATA == CMD_START) begin
              // auto mode: start is only a trigger, and may revive an expiry
              if (st_q == MCWR_NO_TMO || (st_q == MCWR_EXPIRED && !is_auto)) begin
                exc = EXC_BAD_VALUE;
              end else begin
                st_d = MCWR_RUNNING;
              end
            end else if (!is_auto && I_REQ_WDATA == CMD_STOP) begin
              if (st_q == MCWR_NO_TMO || st_q == MCWR_EXPIRED) begin
                exc = EXC_BAD_VALUE;
              end else begin
                st_d = MCWR_STOPPED;
              end
            end else if (!is_auto && I_REQ_WDATA == CMD_RESET) begin
              if (st_q == MCWR_EXPIRED) begin
                st_d = MCWR_STOPPED;
              end else begin
                exc = EXC_BAD_VALUE;
              end
            end else begin
              exc = EXC_BAD_VALUE;
            end
          end
          ADDR_TIMEOUT: begin
            if (st_q == MCWR_RUNNING || st_q == MCWR_EXPIRED) begin
              exc = EXC_BAD_FUNC;
            end else begin
              tmo_d = I_REQ_WDATA;
              if (I_REQ_WDATA == 16'h0000) begin
                st_d = MCWR_NO_TMO;
              end else begin
                st_d = is_auto ? MCWR_RUNNING : MCWR_STOPPED;
              end
            end
          end
          ADDR_CONFIG: begin
            cfg_d = I_REQ_WDATA;
            if (is_auto && !I_REQ_WDATA[CFG_MODE_BIT] && st_q == MCWR_RUNNING) begin
              st_d = MCWR_STOPPED;
            end else if (!is_auto && I_REQ_WDATA[CFG_MODE_BIT] && st_q == MCWR_STOPPED) begin
              st_d = MCWR_RUNNING;
            end
          end
          ADDR_TCP_SUP: begin
            tcp_d = I_REQ_WDATA;
          end
          default: begin
            exc = EXC_BAD_FUNC;
          end
        endcase
      end
      // which accepted requests count as triggers
      if (exc == EXC_NONE) begin
        if (cfg_q[CFG_EXPLICIT_BIT]) begin
          trig = I_REQ_WRITE && I_REQ_ADDR == ADDR_CMD && I_REQ_WDATA == CMD_START;
        end else begin
          trig = I_REQ_WRITE || I_REQ_ADDR != ADDR_STATE || cfg_q[CFG_STATE_TRIG_BIT];
        end
      end
    end
    // auto mode restarts an expired supervision on the next trigger
    if (trig && is_auto && cfg_d[CFG_MODE_BIT] && st_d == MCWR_EXPIRED) begin
      st_d = MCWR_RUNNING;
    end
    restart = (st_d == MCWR_RUNNING) && (trig || st_q != MCWR_RUNNING);
    // expiry loses to a trigger in the same cycle
    if (st_q == MCWR_RUNNING && st_d == MCWR_RUNNING && !restart && tick &&
        ({1'b0, ms_cnt_q} + 17'h00001) >= {1'b0, tmo_q}) begin
      st_d   = MCWR_EXPIRED;
      expire = 1'b1;
    end
  end

  // supervision state and software-visible registers
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_q  <= MCWR_NO_TMO;
      tmo_q <= TIMEOUT_RESET;
      cfg_q <= CONFIG_RESET;
      tcp_q <= TCP_SUP_RESET;
    end else begin
      st_q  <= st_d;
      tmo_q <= tmo_d;
      cfg_q <= cfg_d;
      tcp_q <= tcp_d;
    end
  end

  // step prescaler; restarted with the count so the interval is exact
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pre_q <= '0;
    end else if (restart || st_q != MCWR_RUNNING || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end

  // elapsed 1 ms steps since the last counted trigger
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ms_cnt_q <= 16'h0000;
    end else if (restart || st_q != MCWR_RUNNING) begin
      ms_cnt_q <= 16'h0000;
    end else if (tick) begin
      ms_cnt_q <= ms_cnt_q + 16'h0001;
    end
  end

  // alive word counts served requests so the master sees the slave working
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      alive_q <= 16'h0000;
    end else if (I_REQ_VALID) begin
      alive_q <= alive_q + 16'h0001;
    end
  end

  // answer, one cycle after the request
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RSP_VALID <= 1'b0;
      O_RSP_RDATA <= 16'h0000;
      O_RSP_EXC   <= EXC_NONE;
    end else begin
      O_RSP_VALID <= I_REQ_VALID;
      O_RSP_RDATA <= I_REQ_VALID ? rdata : 16'h0000;
      O_RSP_EXC   <= I_REQ_VALID ? exc : EXC_NONE;
    end
  end

  // timeout response outputs
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_TIMEOUT         <= 1'b0;
      O_CLOSE_TCP       <= 1'b0;
      O_TCP_SUPERVISION <= TCP_SUP_RESET;
    end else begin
      O_TIMEOUT         <= (st_d == MCWR_EXPIRED);
      O_CLOSE_TCP       <= expire && cfg_q[CFG_CLOSE_TCP_BIT];
      O_TCP_SUPERVISION <= tcp_d;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence restart_seq;
    restart && !tick;
  endsequence

  sequence fresh_count_seq;
    ms_cnt_q == 16'h0000 && pre_q == '0 && st_q == MCWR_RUNNING;
  endsequence

  sequence tmo_write_seq;
    I_REQ_VALID && I_REQ_WRITE && I_REQ_ADDR == ADDR_TIMEOUT &&
      (st_q == MCWR_RUNNING || st_q == MCWR_EXPIRED);
  endsequence

  restart_clears_a : assert property (restart_seq |=> fresh_count_seq)
    else $error("counted trigger did not restart the step count");

  expiry_time_a : assert property (
    (st_q == MCWR_RUNNING && tick && !I_REQ_VALID &&
     ({1'b0, ms_cnt_q} + 17'h00001) == {1'b0, tmo_q})
    |=> st_q == MCWR_EXPIRED && O_TIMEOUT)
    else $error("supervision did not expire when the count reached the timeout");

  close_tcp_a : assert property ($rose(O_TIMEOUT) && $past(st_q) == MCWR_RUNNING
    |-> O_CLOSE_TCP == $past(cfg_q[CFG_CLOSE_TCP_BIT]))
    else $error("connection close did not follow its option at expiry");

  tmo_write_lock_a : assert property (tmo_write_seq
    |=> O_RSP_EXC == EXC_BAD_FUNC && $stable(tmo_q))
    else $error("timeout write was not refused while running or expired");

  bad_command_a : assert property (
    I_REQ_VALID && I_REQ_WRITE && I_REQ_ADDR == ADDR_CMD && I_REQ_WDATA != CMD_START &&
    I_REQ_WDATA != CMD_STOP && I_REQ_WDATA != CMD_RESET |=> O_RSP_EXC == EXC_BAD_VALUE)
    else $error("unknown command not answered with the value exception");

  auto_running_a : assert property (
    is_auto && tmo_q != 16'h0000 && st_q != MCWR_EXPIRED |-> st_q == MCWR_RUNNING)
    else $error("auto mode with a timeout set is not running");

  auto_stop_reject_a : assert property (
    is_auto && I_REQ_VALID && I_REQ_WRITE && I_REQ_ADDR == ADDR_CMD && I_REQ_WDATA == CMD_STOP
    |=> O_RSP_EXC == EXC_BAD_VALUE && st_q != MCWR_STOPPED)
    else $error("stop command acted in auto mode");

  mode_back_stop_a : assert property (
    is_auto && st_q == MCWR_RUNNING && I_REQ_VALID && I_REQ_WRITE &&
    I_REQ_ADDR == ADDR_CONFIG && !I_REQ_WDATA[CFG_MODE_BIT] |=> st_q == MCWR_STOPPED)
    else $error("leaving auto mode did not stop supervision");

  state_read_code_a : assert property (
    I_REQ_VALID && !I_REQ_WRITE && I_REQ_ADDR == ADDR_STATE
    |=> O_RSP_RDATA == state_code($past(st_q)))
    else $error("state word does not match the supervision state");

  state_read_notrig_a : assert property (
    st_q == MCWR_RUNNING && I_REQ_VALID && !I_REQ_WRITE && I_REQ_ADDR == ADDR_STATE &&
    !cfg_q[CFG_STATE_TRIG_BIT] && pre_q != '0 && !tick |=> pre_q == $past(pre_q) + PW'(1))
    else $error("state read re-armed the timeout while disabled");

  run_state_a : assert property (
    I_REQ_VALID && !I_REQ_WRITE && I_REQ_ADDR == ADDR_RUN_STATE
    |=> O_RSP_RDATA == ($past(I_CTRL_RUNNING) ? RUN_CODE_RUN : RUN_CODE_STOP))
    else $error("run state word wrong");

  space_size_a : assert property (
    I_REQ_VALID && !I_REQ_WRITE && I_REQ_ADDR == ADDR_IN_DIG |=> O_RSP_RDATA == SIZE_DIGITAL)
    else $error("digital input space size wrong");

endmodule // mcwr_top
`default_nettype wire

/* dv/mcwr_master.sv */
// protocol master model issuing single register requests to the block
`timescale 1ns/1ps
`default_nettype none

module mcwr_master (
  // clock
  input  wire logic        i_clk,
  // request toward the block
  output logic             o_valid,
  output logic             o_write,
  output logic [15:0]      o_addr,
  output logic [15:0]      o_wdata,
  // answer from the block
  input  wire logic        i_rsp_valid,
  input  wire logic [15:0] i_rdata,
  input  wire logic [7:0]  i_exc
);
  // quiet lines at time zero
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_addr  = 16'h0000;
    o_wdata = 16'h0000;
  end

  // one request, held up to its taking edge, then lines scrambled so stale
  // values cannot pass for a fresh request
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] rd, output logic [7:0] ex);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_write <= w;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_write <= ~w;
    o_addr  <= ~a;
    o_wdata <= ~d;
    #1;
    rd = i_rsp_valid ? i_rdata : 16'hdead;
    ex = i_rsp_valid ? i_exc : 8'hee;
  endtask
endmodule // mcwr_master
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the supervision block and its register window
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import mcwr_pkg::*;
  localparam int STEP = 8;
  localparam logic [15:0] RA [28] = '{ADDR_IN_TOTAL, ADDR_IN_ANA, ADDR_IN_DIG, ADDR_OUT_TOTAL,
    ADDR_OUT_ANA, ADDR_OUT_DIG, ADDR_PAT_A, ADDR_PAT_B, ADDR_PAT_C, ADDR_STATE, ADDR_TIMEOUT,
    ADDR_CONFIG, ADDR_TCP_SUP, ADDR_BLINK1, ADDR_BLINK2, ADDR_BLINK3, ADDR_NET0, ADDR_NET1,
    ADDR_NET2, ADDR_FW_LEVEL, ADDR_HW_LEVEL, ADDR_BOOT_LVL, ADDR_CAT0, ADDR_CAT1, ADDR_CAT2,
    ADDR_CAT3, ADDR_IMG_VER, ADDR_ALIVE};
  // alive word is read last: it has counted the 27 requests before it
  localparam logic [15:0] RV [28] = '{16'h7d00, 16'h7d00, 16'h8000, 16'h7d00, 16'h7d00,
    16'h8000, 16'h1234, 16'haaaa, 16'h5555, 16'hffff, 16'h0000, 16'h0000, 16'h0000,
    16'h1a1a, 16'h2b2b, 16'h3c3c, 16'h0123, 16'h4567, 16'h89ab, 16'h0f01, 16'h0f02,
    16'h0f03, 16'h0011, 16'h2233, 16'h4455, 16'h6677, 16'h00c3, 16'h001b};
  logic clk = 1'b0, rstn = 1'b0, run = 1'b1;
  logic [15:0] b1 = 16'h1a1a, b2 = 16'h2b2b, b3 = 16'h3c3c;
  logic v, w, rv, tmo, cls;
  logic [15:0] a, d, rd, tcp;
  logic [7:0] ex;
  int failures = 0, comparisons = 0, cyc = 0;

  // identity words are arbitrary values
  mcwr_top #(.STEP_CYCLES_P(STEP), .CATALOGUE_NUM(64'h0011223344556677),
    .IMAGE_VERSION(16'h00c3)) dut (.I_CLK(clk), .I_RSTN(rstn), .I_REQ_VALID(v),
    .I_REQ_WRITE(w), .I_REQ_ADDR(a), .I_REQ_WDATA(d), .I_BLINK_PART1(b1),
    .I_BLINK_PART2(b2), .I_BLINK_PART3(b3), .I_CTRL_RUNNING(run),
    .I_FW_LEVEL(16'h0f01), .I_HW_LEVEL(16'h0f02), .I_BOOT_LEVEL(16'h0f03),
    .I_NET_HW_ADDR(48'h0123456789ab), .O_RSP_VALID(rv), .O_RSP_RDATA(rd), .O_RSP_EXC(ex),
    .O_TIMEOUT(tmo), .O_CLOSE_TCP(cls), .O_TCP_SUPERVISION(tcp));
  mcwr_master mst (.i_clk(clk), .o_valid(v), .o_write(w), .o_addr(a), .o_wdata(d),
    .i_rsp_valid(rv), .i_rdata(rd), .i_exc(ex));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // one request, judging read data and exception code
  task automatic rq(input logic wr, input logic [15:0] ad, input logic [15:0] wd,
                    input logic [15:0] er, input logic [7:0] ee);
    logic [15:0] g;
    logic [7:0] x;
    mst.xfer(wr, ad, wd, g, x);
    chk("rdata", g, er);
    chk("exc", {8'h00, x}, {8'h00, ee});
  endtask

  task automatic outs(input logic et, input logic ec);
    chk("timeout", {15'h0000, tmo}, {15'h0000, et});
    chk("close", {15'h0000, cls}, {15'h0000, ec});
  endtask

  // fixed words, reset values, refusals in the unconfigured state
  task automatic t_window;
    for (int i = 0; i < 28; i++) rq(1'b0, RA[i], 16'h0000, RV[i], EXC_NONE);
    rq(1'b0, ADDR_RUN_STATE, 16'h0000, RUN_CODE_RUN, EXC_NONE);
    run <= 1'b0;
    rq(1'b0, ADDR_RUN_STATE, 16'h0000, RUN_CODE_STOP, EXC_NONE);
    rq(1'b1, ADDR_CMD, CMD_START, 16'h0000, EXC_BAD_VALUE);
    rq(1'b1, ADDR_CMD, CMD_RESET, 16'h0000, EXC_BAD_VALUE);
    rq(1'b1, ADDR_IN_DIG, 16'h0001, 16'h0000, EXC_BAD_FUNC);
    rq(1'b0, 16'hfaff, 16'h0000, 16'h0000, EXC_BAD_ADDR);
    rq(1'b1, ADDR_TCP_SUP, 16'h00a5, 16'h0000, EXC_NONE);
    rq(1'b0, ADDR_TCP_SUP, 16'h0000, 16'h00a5, EXC_NONE);
    chk("tcp", tcp, 16'h00a5);
  endtask

  // expiry timing, tcp close pulse, commands in the expired state
  task automatic t_expiry;
    rq(1'b1, ADDR_CONFIG, 16'h0001, 16'h0000, EXC_NONE);
    rq(1'b1, ADDR_TIMEOUT, 16'h0003, 16'h0000, EXC_NONE);
    rq(1'b0, ADDR_STATE, 16'h0000, STAT_STOPPED, EXC_NONE);
    rq(1'b1, ADDR_CMD, CMD_START, 16'h0000, EXC_NONE);
    rq(1'b0, ADDR_STATE, 16'h0000, STAT_RUNNING, EXC_NONE);
    repeat (3 * STEP - 3) @(posedge clk);
    #1 outs(1'b0, 1'b0);
    @(posedge clk);
    #1 outs(1'b1, 1'b1);
    @(posedge clk);
    #1 outs(1'b1, 1'b0);
    rq(1'b0, ADDR_STATE, 16'h0000, STAT_EXPIRED, EXC_NONE);
    rq(1'b1, ADDR_TIMEOUT, 16'h0009, 16'h0000, EXC_BAD_FUNC);
    rq(1'b0, ADDR_TIMEOUT, 16'h0000, 16'h0003, EXC_NONE);
    rq(1'b1, ADDR_CMD, CMD_START, 16'h0000, EXC_BAD_VALUE);
    rq(1'b1, ADDR_CMD, CMD_STOP, 16'h0000, EXC_BAD_VALUE);
    rq(1'b1, ADDR_CMD, CMD_RESET, 16'h0000, EXC_NONE);
    rq(1'b0, ADDR_STATE, 16'h0000, STAT_STOPPED, EXC_NONE);
    outs(1'b0, 1'b0);
  endtask

  // an ordinary read late in the interval restarts the count
  task automatic t_retrigger;
    rq(1'b1, ADDR_CMD, CMD_START, 16'h0000, EXC_NONE);
    repeat (3 * STEP - 6) @(posedge clk);
    rq(1'b0, ADDR_IN_TOTAL, 16'h0000, 16'h7d00, EXC_NONE);
    repeat (3 * STEP - 1) @(posedge clk);
    #1 outs(1'b0, 1'b0);
    @(posedge clk);
    #1 outs(1'b1, 1'b1);
    rq(1'b1, ADDR_CMD, CMD_RESET, 16'h0000, EXC_NONE);
  endtask

  // auto-start mode: runs at once, only start allowed, leaving it stops
  task automatic t_auto;
    rq(1'b1, ADDR_CONFIG, 16'h0080, 16'h0000, EXC_NONE);
    rq(1'b0, ADDR_STATE, 16'h0000, STAT_RUNNING, EXC_NONE);
    rq(1'b1, ADDR_CMD, CMD_STOP, 16'h0000, EXC_BAD_VALUE);
    rq(1'b1, ADDR_CMD, CMD_RESET, 16'h0000, EXC_BAD_VALUE);
    rq(1'b1, ADDR_CMD, CMD_START, 16'h0000, EXC_NONE);
    rq(1'b0, ADDR_STATE, 16'h0000, STAT_RUNNING, EXC_NONE);
    rq(1'b1, ADDR_CONFIG, 16'h0000, 16'h0000, EXC_NONE);
    rq(1'b0, ADDR_STATE, 16'h0000, STAT_STOPPED, EXC_NONE);
  endtask

  // trigger options, auto revival after expiry, unknown command, reset mid-run
  task automatic t_options;
    rq(1'b1, ADDR_CONFIG, 16'h0002, 16'h0000, EXC_NONE);
    rq(1'b1, ADDR_CMD, CMD_START, 16'h0000, EXC_NONE);
    repeat (3 * STEP - 6) @(posedge clk);
    rq(1'b0, ADDR_STATE, 16'h0000, STAT_RUNNING, EXC_NONE);
    repeat (3 * STEP - 1) @(posedge clk);
    #1 outs(1'b0, 1'b0);
    @(posedge clk);
    #1 outs(1'b1, 1'b0);
    rq(1'b1, ADDR_CMD, CMD_RESET, 16'h0000, EXC_NONE);
    rq(1'b1, ADDR_CONFIG, 16'h0004, 16'h0000, EXC_NONE);
    rq(1'b1, ADDR_CMD, CMD_START, 16'h0000, EXC_NONE);
    repeat (3 * STEP - 6) @(posedge clk);
    rq(1'b0, ADDR_IN_TOTAL, 16'h0000, SIZE_ANALOG, EXC_NONE);
    repeat (3 * STEP - 21) @(posedge clk);
    #1 outs(1'b0, 1'b0);
    @(posedge clk);
    #1 outs(1'b1, 1'b0);
    rq(1'b1, ADDR_CMD, CMD_RESET, 16'h0000, EXC_NONE);
    rq(1'b1, ADDR_CONFIG, 16'h0080, 16'h0000, EXC_NONE);
    repeat (3 * STEP - 1) @(posedge clk);
    #1 outs(1'b0, 1'b0);
    @(posedge clk);
    #1 outs(1'b1, 1'b0);
    rq(1'b0, ADDR_PAT_A, 16'h0000, PATTERN_A, EXC_NONE);
    rq(1'b0, ADDR_STATE, 16'h0000, STAT_RUNNING, EXC_NONE);
    outs(1'b0, 1'b0);
    rq(1'b1, ADDR_CMD, 16'h1234, 16'h0000, EXC_BAD_VALUE);
    b2 <= 16'h4d4d;
    rq(1'b0, ADDR_BLINK2, 16'h0000, 16'h4d4d, EXC_NONE);
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 outs(1'b0, 1'b0);
    chk("tcp", tcp, 16'h0000);
    rq(1'b0, ADDR_STATE, 16'h0000, STAT_NO_TMO, EXC_NONE);
    rq(1'b0, ADDR_TIMEOUT, 16'h0000, 16'h0000, EXC_NONE);
  endtask

  task automatic conclude;
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // reset for five cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_window();
    t_expiry();
    t_retrigger();
    t_auto();
    t_options();
    conclude();
  end
endmodule // testbench
`default_nettype wire
